// ---- bench/testbench.sv ----
// Self-checking bench for the external data memory interface
`timescale 1ns/1ps
module testbench;
    logic clk, rst_n, page_wr, cfg_wr, ptr_hi_wr, ptr_lo_wr, fifo_map_en, flash_target, mux;
    logic mv_req, mv_write, mv_short, mv_busy, mv_done, ram_en, fifo_en, mem_we, flash_en;
    logic ad_oe, ale_o, rd_n_o, wr_n_o, hit_ram, hit_fifo, hit_flash, hit_we;
    logic [7:0] hit_wdata;
    logic [7:0] reg_wdata, mv_ri, mv_wdata, mv_rdata, ext_page_register, ext_bus_config;
    logic [7:0] pointer_high_byte, pointer_low_byte, mem_wdata, addr_hi_o, addr_lo_o, ad_o, ad_i;
    logic [15:0] mem_addr, hit_addr;
    int fail_count, samples_checked;
    int cycles = 0;
    xmi_top #(.RAM_BYTES(4096)) xmi_top_i (.clk, .rst_n, .page_wr, .cfg_wr, .ptr_hi_wr,
        .ptr_lo_wr, .reg_wdata, .fifo_map_en, .flash_target, .mv_req, .mv_write, .mv_short,
        .mv_ri, .mv_wdata, .mv_busy, .mv_done, .mv_rdata, .ext_page_register, .ext_bus_config,
        .pointer_high_byte, .pointer_low_byte, .ram_en, .fifo_en, .mem_we, .mem_addr,
        .mem_wdata, .ram_rdata(~mem_addr[7:0]), .fifo_rdata(mem_addr[7:0]), .flash_en,
        .addr_hi_o, .addr_lo_o, .ad_o, .ad_oe, .ad_i, .ale_o, .rd_n_o, .wr_n_o);
    xmi_sram_model xmi_sram_model_i (.clk, .mux, .ad_o, .ad_oe, .ad_i, .ale_o, .rd_n_o,
        .wr_n_o, .addr_hi_o, .addr_lo_o);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (mv_req && !mv_busy) {hit_ram, hit_fifo, hit_flash, hit_we} <= 4'h0;
        if (ram_en || fifo_en) hit_addr <= mem_addr;
        if (mem_we) {hit_we, hit_wdata} <= {1'b1, mem_wdata};
        if (ram_en) hit_ram <= 1'b1;
        if (fifo_en) hit_fifo <= 1'b1;
        if (flash_en) hit_flash <= 1'b1;
        if (cycles == 2000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr_reg(int which, logic [7:0] v);
        @(posedge clk);
        reg_wdata <= v;
        page_wr <= which == 0;
        cfg_wr <= which == 1;
        ptr_hi_wr <= which == 2;
        ptr_lo_wr <= which == 3;
        @(posedge clk);
        {page_wr, cfg_wr, ptr_hi_wr, ptr_lo_wr} <= 4'h0;
    endtask : wr_reg
    task automatic mv(logic w, logic s, logic [7:0] ri, logic [7:0] d);
        @(posedge clk);
        {mv_req, mv_write, mv_short, mv_ri, mv_wdata} <= {1'b1, w, s, ri, d};
        @(posedge clk);
        mv_req <= 1'b0;
        for (int i = 0; i < 20 && mv_done !== 1'b1; i++) @(posedge clk);
        chk("done", 16'h1, mv_done);
    endtask : mv
    task automatic t_regs;
        wr_reg(0, 8'h0f);
        wr_reg(2, 8'h00);
        wr_reg(3, 8'h40);
        @(posedge clk);
        chk("page", 16'h0f, ext_page_register);
        chk("ptr", 16'h0040, {pointer_high_byte, pointer_low_byte});
    endtask : t_regs
    task automatic t_onchip;
        mv(1'b0, 1'b0, 8'h00, 8'h00);
        chk("ram16", 16'h1040, {3'h0, hit_ram, 4'h0, hit_addr[7:0]});
        chk("rd16", 16'hbf, mv_rdata);
        mv(1'b0, 1'b1, 8'hfe, 8'h00);
        chk("ramtop", 16'h0ffe, hit_addr);
        chk("rdtop", 16'h01, mv_rdata);
        mv(1'b1, 1'b1, 8'h20, 8'h3c);
        chk("ramwr", 16'h013c, {7'h0, hit_we, hit_wdata});
        chk("ramwra", 16'h0f20, hit_addr);
        wr_reg(0, 8'h10);
        fifo_map_en <= 1'b1;
        mv(1'b0, 1'b1, 8'h05, 8'h00);
        chk("fifo", 16'h1005, hit_fifo ? hit_addr : 16'h0);
        chk("fiford", 16'h05, mv_rdata);
        fifo_map_en <= 1'b0;
        mv(1'b0, 1'b1, 8'h05, 8'h00);
        chk("unmapped", 16'h0, {hit_fifo, hit_ram});
    endtask : t_onchip
    task automatic t_mux;
        wr_reg(1, 8'h00);
        mux <= 1'b1;
        wr_reg(0, 8'h23);
        mv(1'b1, 1'b1, 8'h45, 8'ha5);
        mv(1'b1, 1'b1, 8'h46, 8'h5a);
        mv(1'b0, 1'b1, 8'h45, 8'h00);
        chk("muxrd", 16'ha5, mv_rdata);
        chk("offchip", 16'h0, hit_ram);
    endtask : t_mux
    task automatic t_nonmux;
        mux <= 1'b0;
        for (int m = 5; m < 8; m++) begin
            wr_reg(1, 8'(m << 2));
            mv(1'b1, 1'b1, 8'(8'h60 + m), 8'(m ^ 8'h3c));
            mv(1'b0, 1'b1, 8'(8'h60 + m), 8'h00);
            chk("nmrd", 16'(m ^ 8'h3c), mv_rdata);
            chk("cfg", 16'(m << 2), ext_bus_config);
        end
    endtask : t_nonmux
    task automatic t_flash;
        flash_target <= 1'b1;
        mv(1'b1, 1'b1, 8'h10, 8'h77);
        chk("flash", 16'h1, {hit_ram, hit_flash});
        flash_target <= 1'b0;
    endtask : t_flash
    task automatic t_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk("rstpage", 16'h0, ext_page_register);
        chk("rstpins", 16'h0018, {ale_o, rd_n_o, wr_n_o, ad_oe, mv_busy, mv_done});
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        mv(1'b0, 1'b0, 8'h00, 8'h00);
        chk("rstptr", 16'h1000, {3'h0, hit_ram, hit_addr[11:0]});
        chk("rstrd", 16'hff, mv_rdata);
    endtask : t_reset
    task automatic close_out;
        $display("Mismatches %0d, comparisons %0d", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    initial begin
        {rst_n, page_wr, cfg_wr, ptr_hi_wr, ptr_lo_wr, fifo_map_en, flash_target} = '0;
        {mv_req, mv_write, mv_short, mux} = '0;
        {reg_wdata, mv_ri, mv_wdata} = '0;
        {fail_count, samples_checked} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_onchip();
        t_mux();
        t_nonmux();
        t_flash();
        t_reset();
        close_out();
    end
endmodule : testbench
bind xmi_top xmi_checker xmi_checker_i (.clk, .rst_n, .ale_o, .rd_n_o, .wr_n_o, .ad_oe,
    .ad_o, .addr_lo_o, .ext_bus_config, .mv_done);

// ---- bench/xmi_checker.sv ----
// Bus sequencing checker for the external data memory interface
`timescale 1ns/1ps
module xmi_checker (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // Observed outputs
    input wire logic       ale_o,
    input wire logic       rd_n_o,
    input wire logic       wr_n_o,
    input wire logic       ad_oe,
    input wire logic [7:0] ad_o,
    input wire logic [7:0] addr_lo_o,
    input wire logic [7:0] ext_bus_config,
    input wire logic       mv_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_hold;
        !ale_o ##1 (!rd_n_o || !wr_n_o);
    endsequence
    sequence s_wr_pulse;
        !wr_n_o [*3] ##1 wr_n_o;
    endsequence
    a_ale_addr_low: assert property (ale_o |-> ad_oe && ad_o == addr_lo_o)
        else $error("strobe high without low address on shared pins");
    a_ale_then_data: assert property ($rose(ale_o) |=> s_hold)
        else $error("hold phase not followed by read or write strobe");
    a_wr_strobe_len: assert property ($fell(wr_n_o) |-> s_wr_pulse)
        else $error("write strobe not three cycles");
    a_rd_strobe_len: assert property ($fell(rd_n_o) |-> !rd_n_o [*3] ##1 rd_n_o)
        else $error("read strobe not three cycles");
    a_wr_drives: assert property (!wr_n_o |-> ad_oe)
        else $error("write strobe without data drive");
    a_rd_release: assert property (!rd_n_o |-> !ad_oe)
        else $error("data pins driven during read");
    a_nomux_no_ale: assert property (ext_bus_config[4] |-> !ale_o)
        else $error("latch strobe in non-multiplexed mode");
    a_strobe_done: assert property ($rose(wr_n_o) || $rose(rd_n_o) |-> mv_done)
        else $error("move not done when strobe ends");
endmodule : xmi_checker

// ---- bench/xmi_sram_model.sv ----
// Off-chip byte memory behind an external address latch
`timescale 1ns/1ps
module xmi_sram_model (
    // Clock and mode
    input  wire logic       clk,
    input  wire logic       mux,
    // Bus pins
    input  wire logic [7:0] ad_o,
    input  wire logic       ad_oe,
    output logic [7:0]      ad_i,
    input  wire logic       ale_o,
    input  wire logic       rd_n_o,
    input  wire logic       wr_n_o,
    input  wire logic [7:0] addr_hi_o,
    input  wire logic [7:0] addr_lo_o
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  lat_q;
    logic [7:0]  last_q = 8'h00;
    logic [15:0] a;
    // Transparent while strobe high, frozen after its fall
    always_latch if (ale_o) lat_q <= ad_o;
    // Muxed mode trusts only the latch, never the direct low pins
    assign a = {addr_hi_o, mux ? lat_q : addr_lo_o};
    always @(posedge clk) if (!wr_n_o && ad_oe) mem[a] <= ad_o;
    // Released bus toggles so a stale value cannot pass
    always @(posedge clk) last_q <= ad_i;
    assign ad_i = !rd_n_o ? mem[a] : ~last_q;
endmodule : xmi_sram_model

// ---- logic/xmi_decode.sv ----
// Address decoder: on-chip RAM, mapped USB FIFO space or the external bus
`timescale 1ns/1ps
module xmi_decode import xmi_pkg::*; #(
    parameter int RAM_BYTES = RAM_BYTES_DEF
) (
    // Address and options
    input  wire logic [15:0] addr,
    input  wire logic        fifo_map_en,
    // Decision
    output xmi_sel_t         sel
);
    if (RAM_BYTES != 4096 && RAM_BYTES != 2048) begin : g_bad_ram
        $error("RAM_BYTES must be 2048 or 4096");
    end

    localparam logic [16:0] RAM_END  = 17'(RAM_BYTES);
    localparam logic [16:0] FIFO_END = 17'(FIFO_BASE) + 17'(FIFO_BYTES);

    always_comb begin
        if ({1'b0, addr} < RAM_END)
            sel = XMI_SEL_RAM;
        else if (fifo_map_en && addr >= FIFO_BASE && {1'b0, addr} < FIFO_END)
            sel = XMI_SEL_FIFO;
        else
            sel = XMI_SEL_EXT;
    end
endmodule : xmi_decode

// ---- logic/xmi_top.sv ----
// External data memory interface: address forming, decode and bus sequencing
`timescale 1ns/1ps
module xmi_top import xmi_pkg::*; #(
    parameter int RAM_BYTES = RAM_BYTES_DEF
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Core register writes
    input  wire logic        page_wr,
    input  wire logic        cfg_wr,
    input  wire logic        ptr_hi_wr,
    input  wire logic        ptr_lo_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        fifo_map_en,
    input  wire logic        flash_target,
    // Core move request
    input  wire logic        mv_req,
    input  wire logic        mv_write,
    input  wire logic        mv_short,
    input  wire logic [7:0]  mv_ri,
    input  wire logic [7:0]  mv_wdata,
    output logic             mv_busy,
    output logic             mv_done,
    output logic [7:0]       mv_rdata,
    // Register readback
    output logic [7:0]       ext_page_register,
    output logic [7:0]       ext_bus_config,
    output logic [7:0]       pointer_high_byte,
    output logic [7:0]       pointer_low_byte,
    // On-chip RAM and FIFO port
    output logic             ram_en,
    output logic             fifo_en,
    output logic             mem_we,
    output logic [15:0]      mem_addr,
    output logic [7:0]       mem_wdata,
    input  wire logic [7:0]  ram_rdata,
    input  wire logic [7:0]  fifo_rdata,
    // Flash write path
    output logic             flash_en,
    // External bus pins
    output logic [7:0]       addr_hi_o,
    output logic [7:0]       addr_lo_o,
    output logic [7:0]       ad_o,
    output logic             ad_oe,
    input  wire logic [7:0]  ad_i,
    output logic             ale_o,
    output logic             rd_n_o,
    output logic             wr_n_o
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ONCHIP,
        ST_ALE,
        ST_HOLD,
        ST_STROBE,
        ST_DONE
    } xmi_state_t;

    logic        rst_s1_r, rst_s2_r;
    logic [7:0]  ad_s1_r, ad_s2_r;
    logic [7:0]  page_r, cfg_r;
    logic [15:0] ptr_r;
    logic [15:0] eff_addr;
    logic [15:0] addr_r;
    logic        wr_r;
    logic [7:0]  wdata_r;
    logic [7:0]  rdata_r;
    xmi_sel_t    sel, sel_r;
    xmi_state_t  state_r, state_nxt;
    logic [1:0]  cnt_r;
    logic        mux_mode;
    logic        nm16;
    logic        done_r;

    // Reset release synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // Pin inputs from the external bus
    always_ff @(posedge clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            ad_s1_r <= 8'h00;
            ad_s2_r <= 8'h00;
        end else begin
            ad_s1_r <= ad_i;
            ad_s2_r <= ad_s1_r;
        end
    end

    // Page, configuration and pointer registers
    always_ff @(posedge clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            page_r <= PAGE_RESET;
            cfg_r  <= CFG_RESET;
            ptr_r  <= PTR_RESET;
        end else begin
            if (page_wr)
                page_r <= reg_wdata;
            if (cfg_wr)
                cfg_r <= reg_wdata;
            if (ptr_hi_wr)
                ptr_r[15:8] <= reg_wdata;
            if (ptr_lo_wr)
                ptr_r[7:0] <= reg_wdata;
        end
    end

    assign ext_page_register = page_r;
    assign ext_bus_config    = cfg_r;
    assign pointer_high_byte = ptr_r[15:8];
    assign pointer_low_byte  = ptr_r[7:0];

    // Effective address: page plus Ri, or the full pointer
    assign eff_addr = mv_short ? {page_r, mv_ri}
                               : ptr_r;

    // Multiplexed when bit 4 is clear
    assign mux_mode = !cfg_r[CFG_MUX_BIT];
    assign nm16 = (cfg_r[CFG_MODE_LO+2:CFG_MODE_LO] == MODE_NM16_A)
               || (cfg_r[CFG_MODE_LO+2:CFG_MODE_LO] == MODE_NM16_B)
               || (cfg_r[CFG_MODE_LO+2:CFG_MODE_LO] == MODE_NM16_C);

    xmi_decode #(
        .RAM_BYTES   (RAM_BYTES)
    ) u_decode (
        .addr        (eff_addr),
        .fifo_map_en (fifo_map_en),
        .sel         (sel)
    );

    // Bus sequencer
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (mv_req && !flash_target) begin
                    if (sel == XMI_SEL_EXT)
                        state_nxt = (mux_mode && !nm16) ? ST_ALE : ST_STROBE;
                    else
                        state_nxt = ST_ONCHIP;
                end else if (mv_req)
                    state_nxt = ST_DONE;
            end
            ST_ONCHIP: state_nxt = ST_DONE;
            ST_ALE:    if (cnt_r == 2'(ALE_CYC - 1)) state_nxt = ST_HOLD;
            ST_HOLD:   if (cnt_r == 2'(HOLD_CYC - 1)) state_nxt = ST_STROBE;
            ST_STROBE: if (cnt_r == 2'(STROBE_CYC - 1)) state_nxt = ST_DONE;
            ST_DONE:   state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            state_r <= ST_IDLE;
            cnt_r   <= 2'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= (state_nxt != state_r) ? 2'h0 : cnt_r + 2'h1;
        end
    end

    // Capture of the request
    always_ff @(posedge clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            addr_r  <= 16'h0000;
            wr_r    <= 1'b0;
            wdata_r <= 8'h00;
            sel_r   <= XMI_SEL_NONE;
        end else if (state_r == ST_IDLE && mv_req) begin
            addr_r  <= eff_addr;
            wr_r    <= mv_write;
            wdata_r <= mv_wdata;
            sel_r   <= flash_target ? XMI_SEL_NONE : sel;
        end
    end

    // Read data: on-chip after one cycle, external at the strobe's end
    always_ff @(posedge clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            rdata_r <= 8'h00;
            done_r  <= 1'b0;
        end else begin
            done_r <= (state_nxt == ST_DONE) && (state_r != ST_DONE);
            if (state_r == ST_ONCHIP && !wr_r)
                rdata_r <= (sel_r == XMI_SEL_FIFO) ? fifo_rdata : ram_rdata;
            else if (state_r == ST_STROBE && state_nxt == ST_DONE && !wr_r)
                rdata_r <= ad_s2_r; // Sync delay: sees the pins from the strobe's first cycle
        end
    end

    assign mv_busy  = (state_r != ST_IDLE);
    assign mv_done  = done_r;
    assign mv_rdata = rdata_r;

    // On-chip memory port
    assign ram_en    = (state_r == ST_ONCHIP) && (sel_r == XMI_SEL_RAM);
    assign fifo_en   = (state_r == ST_ONCHIP) && (sel_r == XMI_SEL_FIFO);
    assign mem_we    = (state_r == ST_ONCHIP) && wr_r;
    assign mem_addr  = addr_r;
    assign mem_wdata = wdata_r;
    assign flash_en  = (state_r == ST_IDLE) && mv_req && flash_target && mv_write;

    // External pins
    logic ext_act;
    logic mux_cyc;
    assign ext_act = (state_r == ST_ALE) || (state_r == ST_HOLD) || (state_r == ST_STROBE);
    assign mux_cyc = mux_mode && !nm16;

    always_ff @(posedge clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            addr_hi_o <= 8'h00;
            addr_lo_o <= 8'h00;
            ad_o      <= 8'h00;
            ad_oe     <= 1'b0;
            ale_o     <= 1'b0;
            rd_n_o    <= 1'b1;
            wr_n_o    <= 1'b1;
        end else begin
            addr_hi_o <= (state_nxt == ST_IDLE) ? 8'h00 : addr_r[15:8];
            if (state_r == ST_IDLE && mv_req) begin
                addr_hi_o <= eff_addr[15:8];
                addr_lo_o <= eff_addr[7:0];
            end
            ale_o  <= (state_nxt == ST_ALE);
            rd_n_o <= !((state_nxt == ST_STROBE) && !mv_write_hold(state_r, wr_r, mv_write));
            wr_n_o <= !((state_nxt == ST_STROBE) && mv_write_hold(state_r, wr_r, mv_write));
            if (state_nxt == ST_ALE) begin
                ad_o  <= eff_addr[7:0];
                ad_oe <= 1'b1;
            end else if (state_nxt == ST_HOLD && mux_cyc) begin
                ad_o  <= addr_r[7:0];
                ad_oe <= 1'b1;
            end else if (state_nxt == ST_STROBE) begin
                ad_o  <= (state_r == ST_IDLE) ? mv_wdata : wdata_r;
                ad_oe <= (state_r == ST_IDLE) ? mv_write : wr_r;
            end else begin
                ad_oe <= 1'b0;
            end
            if (!ext_act && state_nxt == ST_IDLE)
                addr_lo_o <= addr_lo_o;
        end
    end

    function automatic logic mv_write_hold(input xmi_state_t st, input logic held,
                                           input logic live);
        mv_write_hold = (st == ST_IDLE) ? live : held;
    endfunction : mv_write_hold
endmodule : xmi_top

// ---- pkg/xmi_pkg.sv ----
// Constants and types for the external data memory interface
package xmi_pkg;
    localparam int ADDR_W          = 16;
    localparam int DATA_W          = 8;
    // Configuration field positions
    localparam int CFG_MUX_BIT     = 4;
    localparam int CFG_MODE_LO     = 2;
    localparam logic [2:0] MODE_NM16_A = 3'h5;
    localparam logic [2:0] MODE_NM16_B = 3'h6;
    localparam logic [2:0] MODE_NM16_C = 3'h7;
    localparam logic [7:0] CFG_RESET   = 8'h00;
    localparam logic [7:0] PAGE_RESET  = 8'h00;
    localparam logic [15:0] PTR_RESET  = 16'h0000;
    // On-chip memory map
    localparam logic [15:0] RAM_BASE   = 16'h0000;
    localparam int RAM_BYTES_DEF       = 4096;
    localparam logic [15:0] FIFO_BASE  = 16'h1000;
    localparam int FIFO_BYTES          = 1024;
    // Bus phase lengths in clock cycles
    localparam int ALE_CYC             = 1;
    localparam int HOLD_CYC            = 1;
    localparam int STROBE_CYC          = 3; // Two sync flops need the third strobe cycle
    typedef enum logic [1:0] {
        XMI_SEL_NONE,
        XMI_SEL_RAM,
        XMI_SEL_FIFO,
        XMI_SEL_EXT
    } xmi_sel_t;
endpackage : xmi_pkg
